// >>> rtl/mbod_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants and types for the multiply/branch opcode decoder
// ---------------------------------------------------------------------------
package mbod_pkg;

	// ---------------------------------------------------------------------
	// Decoded operation codes
	// ---------------------------------------------------------------------
	typedef enum logic [5:0] {
		OP_UNKNOWN,                // Word is outside both groups
		OP_ADD_PRODUCT_TO_ACC,
		OP_LOAD_ACC_FROM_PRODUCT,
		OP_SUB_PRODUCT_FROM_ACC,
		OP_SET_SHIFT_SELECT,
		OP_LOAD_FACTOR_REG,
		OP_LOAD_T_ADD_PRODUCT,
		OP_LOAD_T_ADD_SHIFT_DATA,
		OP_LOAD_T_COPY_PRODUCT,
		OP_LOAD_T_SUB_PRODUCT,
		OP_MULTIPLY_WORD,
		OP_MULTIPLY_ADD_PRIOR,
		OP_MULTIPLY_IMMEDIATE,
		OP_MULTIPLY_SUB_PRIOR,
		OP_MULTIPLY_UNSIGNED,
		OP_SQUARE_ADD,
		OP_SQUARE_SUB,
		OP_MUL_ACC_TWOWORD,
		OP_MUL_ACC_MOVE,
		OP_LOAD_PRODUCT_HIGH,
		OP_STORE_PRODUCT_HIGH,
		OP_STORE_PRODUCT_LOW,
		OP_JUMP_ALWAYS,
		OP_JUMP_TO_ACC_TARGET,
		OP_JUMP_AUX_NONZERO,
		OP_JUMP_TEST_SET,
		OP_JUMP_TEST_CLEAR,
		OP_JUMP_ACC_NONNEG,
		OP_JUMP_ACC_POSITIVE,
		OP_JUMP_ACC_NONPOS,
		OP_JUMP_ACC_NEGATIVE,
		OP_JUMP_IO_LOW,
		OP_JUMP_NO_OVERFLOW,
		OP_JUMP_ON_CARRY,
		OP_JUMP_NO_CARRY
	} mbod_op_type;

	// Branch condition handed to the branch logic
	typedef enum logic [3:0] {
		COND_NONE,
		COND_ALWAYS,
		COND_AUX_NONZERO,
		COND_TEST_SET,
		COND_TEST_CLEAR,
		COND_ACC_NONNEG,
		COND_ACC_POSITIVE,
		COND_ACC_NONPOS,
		COND_ACC_NEGATIVE,
		COND_IO_LOW,
		COND_NO_OVERFLOW,
		COND_ON_CARRY,
		COND_NO_CARRY
	} mbod_cond_type;

	// ---------------------------------------------------------------------
	// Register map (byte addresses) and field positions
	// ---------------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;   // bit 0 fetch enable
	localparam logic [7:0] REG_WORD = 8'h04;   // write injects a word
	localparam logic [7:0] REG_STATUS = 8'h08; // decoder state
	localparam logic [7:0] REG_FIELDS = 8'h0C; // operand fields
	localparam logic [7:0] REG_TARGET = 8'h10; // second word
	localparam logic [7:0] REG_COUNT = 8'h14;  // decoded count
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam int ST_WAIT_BIT = 0;
	localparam int ST_TWO_BIT = 1;
	localparam int ST_UNK_BIT = 2;
	localparam int ST_MEM_BIT = 3;
	localparam int ST_OP_LSB = 8;
	localparam int ST_COND_LSB = 16;
	localparam int FLD_IMM_LSB = 0;
	localparam int FLD_SHIFT_LSB = 13;
	localparam int FLD_OFS_LSB = 16;
	localparam int FLD_IND_BIT = 23;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : mbod_pkg

// >>> rtl/mbod_dec_if.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Word under decode and its decoded pieces
// ---------------------------------------------------------------------------
interface mbod_dec_if;
	import mbod_pkg::*;
	logic [15:0] word;            // Word being classified
	mbod_op_type op;              // Recognised operation
	mbod_cond_type cond;          // Branch condition
	logic two_word;               // A second word follows
	logic mem_op;                 // Word carries a memory operand
	logic indirect;               // Indirect addressing selected
	logic [6:0] page_offset;      // Direct page offset or indirect control
	logic [12:0] mul_imm;         // Multiply constant
	logic [1:0] shift_sel;        // Product shift mode
	modport main_mp (output word, input op, cond, two_word, mem_op, indirect, page_offset, mul_imm, shift_sel);
	modport match_mp (input word, output op, cond, two_word, mem_op);
	modport field_mp (input word, output indirect, page_offset, mul_imm, shift_sel);
endinterface : mbod_dec_if

// >>> rtl/mbod_match.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Opcode pattern classifier
// ---------------------------------------------------------------------------
module mbod_match (
	mbod_dec_if.match_mp dif
);
	import mbod_pkg::*;

	// Patterns never overlap, so order only matters for readability
	always_comb begin
		dif.op = OP_UNKNOWN;
		dif.cond = COND_NONE;
		dif.two_word = 1'b0;
		dif.mem_op = 1'b1;
		casez (dif.word)
			16'hCE15: dif.op = OP_ADD_PRODUCT_TO_ACC;
			16'hCE14: dif.op = OP_LOAD_ACC_FROM_PRODUCT;
			16'hCE16: dif.op = OP_SUB_PRODUCT_FROM_ACC;
			16'b11001110000010??: dif.op = OP_SET_SHIFT_SELECT;
			16'h3C??: dif.op = OP_LOAD_FACTOR_REG;
			16'h3D??: dif.op = OP_LOAD_T_ADD_PRODUCT;
			16'h3F??: dif.op = OP_LOAD_T_ADD_SHIFT_DATA;
			16'h3E??: dif.op = OP_LOAD_T_COPY_PRODUCT;
			16'h5B??: dif.op = OP_LOAD_T_SUB_PRODUCT;
			16'h38??: dif.op = OP_MULTIPLY_WORD;
			16'h3A??: dif.op = OP_MULTIPLY_ADD_PRIOR;
			16'b101?????????????: dif.op = OP_MULTIPLY_IMMEDIATE;
			16'h3B??: dif.op = OP_MULTIPLY_SUB_PRIOR;
			16'hCF??: dif.op = OP_MULTIPLY_UNSIGNED;
			16'h39??: dif.op = OP_SQUARE_ADD;
			16'h5A??: dif.op = OP_SQUARE_SUB;
			16'h5D??: dif.op = OP_MUL_ACC_TWOWORD;
			16'h5C??: dif.op = OP_MUL_ACC_MOVE;
			16'h53??: dif.op = OP_LOAD_PRODUCT_HIGH;
			16'h7D??: dif.op = OP_STORE_PRODUCT_HIGH;
			16'h7C??: dif.op = OP_STORE_PRODUCT_LOW;
			16'b111111111???????: dif.op = OP_JUMP_ALWAYS;
			16'hCE25: dif.op = OP_JUMP_TO_ACC_TARGET;
			16'b111110111???????: dif.op = OP_JUMP_AUX_NONZERO;
			16'b111110011???????: dif.op = OP_JUMP_TEST_SET;
			16'b111110001???????: dif.op = OP_JUMP_TEST_CLEAR;
			16'b111101001???????: dif.op = OP_JUMP_ACC_NONNEG;
			16'b111100011???????: dif.op = OP_JUMP_ACC_POSITIVE;
			16'b111100101???????: dif.op = OP_JUMP_ACC_NONPOS;
			16'b111100111???????: dif.op = OP_JUMP_ACC_NEGATIVE;
			16'b111110101???????: dif.op = OP_JUMP_IO_LOW;
			16'b111101111???????: dif.op = OP_JUMP_NO_OVERFLOW;
			16'b010111101???????: dif.op = OP_JUMP_ON_CARRY;
			16'b010111111???????: dif.op = OP_JUMP_NO_CARRY;
			default: dif.op = OP_UNKNOWN;
		endcase
		// Word count, condition and operand presence per operation
		unique case (dif.op)
			OP_ADD_PRODUCT_TO_ACC, OP_LOAD_ACC_FROM_PRODUCT, OP_SUB_PRODUCT_FROM_ACC,
			OP_SET_SHIFT_SELECT, OP_MULTIPLY_IMMEDIATE, OP_UNKNOWN: dif.mem_op = 1'b0;
			OP_MUL_ACC_TWOWORD, OP_MUL_ACC_MOVE: dif.two_word = 1'b1;
			OP_JUMP_TO_ACC_TARGET: begin
				dif.mem_op = 1'b0;
				dif.cond = COND_ALWAYS;
			end
			OP_JUMP_ALWAYS, OP_JUMP_AUX_NONZERO, OP_JUMP_TEST_SET, OP_JUMP_TEST_CLEAR,
			OP_JUMP_ACC_NONNEG, OP_JUMP_ACC_POSITIVE, OP_JUMP_ACC_NONPOS, OP_JUMP_ACC_NEGATIVE,
			OP_JUMP_IO_LOW, OP_JUMP_NO_OVERFLOW, OP_JUMP_ON_CARRY, OP_JUMP_NO_CARRY: begin
				// Low bits of a branch word are not a data operand
				dif.mem_op = 1'b0;
				dif.two_word = 1'b1;
			end
			default: dif.mem_op = 1'b1;
		endcase
		// Condition the branch logic must test
		unique case (dif.op)
			OP_JUMP_ALWAYS: dif.cond = COND_ALWAYS;
			OP_JUMP_AUX_NONZERO: dif.cond = COND_AUX_NONZERO;
			OP_JUMP_TEST_SET: dif.cond = COND_TEST_SET;
			OP_JUMP_TEST_CLEAR: dif.cond = COND_TEST_CLEAR;
			OP_JUMP_ACC_NONNEG: dif.cond = COND_ACC_NONNEG;
			OP_JUMP_ACC_POSITIVE: dif.cond = COND_ACC_POSITIVE;
			OP_JUMP_ACC_NONPOS: dif.cond = COND_ACC_NONPOS;
			OP_JUMP_ACC_NEGATIVE: dif.cond = COND_ACC_NEGATIVE;
			OP_JUMP_IO_LOW: dif.cond = COND_IO_LOW;
			OP_JUMP_NO_OVERFLOW: dif.cond = COND_NO_OVERFLOW;
			OP_JUMP_ON_CARRY: dif.cond = COND_ON_CARRY;
			OP_JUMP_NO_CARRY: dif.cond = COND_NO_CARRY;
			default: ;
		endcase
	end

endmodule : mbod_match

// >>> rtl/mbod_fields.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Operand field extraction
// ---------------------------------------------------------------------------
module mbod_fields (
	mbod_dec_if.field_mp dif
);
	import mbod_pkg::*;

	// Fields are cut unconditionally; the op code says which one is meaningful
	always_comb begin
		dif.indirect = dif.word[7];
		dif.page_offset = dif.word[6:0];
		dif.mul_imm = dif.word[12:0];
		dif.shift_sel = dif.word[1:0];
	end

endmodule : mbod_fields

// >>> rtl/mbod_decoder.sv
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
// Operation
// - CE15 decodes as add product to accumulator
// - CE14 decodes as load accumulator from product
// - CE16 decodes as subtract product from accumulator
// - Shift select word passes bits 1:0
// - 3C, 3D bytes: load factor variants
// - 3F byte: load factor, add, move data
// - 3E byte: load factor, copy product
// - 5B byte: load factor, subtract product
// - 38 byte: multiply memory word
// - 3A multiply-add; 101 top: immediate multiply
// - 3B multiply-subtract; CF unsigned multiply
// - 39 square-add; 5A square-subtract
// - 5D and 5C are two-word multiply-accumulates
// - 53 byte: load product high half
// - 7D byte: store product high half
// - 7C byte: store product low half
// - Unconditional jump two words; CE25 accumulator jump
// - Auxiliary-nonzero jump is two words
// - Test-flag set/clear jumps, two words
// - Four accumulator-sign jumps, two words
// - Polled-input-low jump, two words
// - Overflow and carry jumps, two words
module mbod_decoder (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// Fetch side
	input wire logic i_fetch_valid,
	input wire logic [15:0] i_fetch_word,
	// Decoded instruction
	output logic o_dec_valid,
	output mbod_pkg::mbod_op_type o_op,
	output mbod_pkg::mbod_cond_type o_cond,
	output logic o_two_word,
	output logic o_unknown,
	output logic o_mem_op,
	output logic o_indirect,
	output logic [6:0] o_page_offset,
	output logic [12:0] o_mul_imm,
	output logic [1:0] o_shift_sel,
	output logic [15:0] o_target,
	output logic o_wait_target,
	// AXI4-Lite slave
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready
);
	import mbod_pkg::*;

	// -----------------------------------------------------------------------
	// State
	// -----------------------------------------------------------------------
	// Decoder sequencer: opcode expected, or the extension word
	typedef enum logic {
		SEQ_OPCODE,
		SEQ_TARGET
	} mbod_seq_type;

	// Every flip-flop of the module lives in this one struct
	typedef struct packed {
		mbod_seq_type seq;      // Sequencer state
		logic enable;           // Fetch port enable
		logic [15:0] word;      // Last opcode word taken
		logic dec_valid;        // One-cycle decode strobe
		mbod_op_type op;        // Held operation
		mbod_cond_type cond;    // Held condition
		logic two_word;         // Held word count flag
		logic unknown;          // Held unknown flag
		logic mem_op;           // Held operand flag
		logic indirect;         // Held indirect select
		logic [6:0] page_offset; // Held offset or control
		logic [12:0] mul_imm;   // Held multiply constant
		logic [1:0] shift_sel;  // Held shift mode
		logic [15:0] target;    // Held second word
		logic [31:0] count;     // Decoded instruction count
		logic awready;          // Write address slot free
		logic [7:0] awaddr;     // Captured write address
		logic wready;           // Write data slot free
		logic [31:0] wdata;     // Captured write data
		logic [3:0] wstrb;      // Captured byte enables
		logic bvalid;           // Write response pending
		logic [1:0] bresp;      // Write response code
		logic arready;          // Read slot free
		logic rvalid;           // Read data pending
		logic [31:0] rdata;     // Read data
		logic [1:0] rresp;      // Read response code
	} mbod_state_type;

	mbod_state_type q; // Registered state
	mbod_state_type d; // Next state

	// -----------------------------------------------------------------------
	// Classifier and field extractor
	// -----------------------------------------------------------------------
	mbod_dec_if dif (); // Shared decode bundle

	mbod_match u_match (
		.dif(dif.match_mp)
	);

	mbod_fields u_fields (
		.dif(dif.field_mp)
	);

	// -----------------------------------------------------------------------
	// Word source selection
	// -----------------------------------------------------------------------
	logic wr_ready;       // Both write halves captured, no response out
	logic wr_word_hit;    // Pending write targets the word register
	logic wr_stall;       // Word write must wait for the fetch port
	logic fetch_take;     // Fetch port word accepted this cycle
	logic inject_take;    // Software word accepted this cycle
	logic [15:0] inj_word; // Software word merged under its strobes
	logic word_take;      // Any word accepted this cycle
	logic [15:0] word_in; // Accepted word

	// Fetch has priority; a software word stalls the write channel instead
	always_comb begin
		wr_ready = !q.awready && !q.wready && !q.bvalid;
		wr_word_hit = (q.awaddr == REG_WORD);
		fetch_take = i_fetch_valid && q.enable;
		wr_stall = wr_word_hit && fetch_take;
		inject_take = wr_ready && wr_word_hit && !fetch_take;
		inj_word[7:0] = q.wstrb[0] ? q.wdata[7:0] : q.word[7:0];
		inj_word[15:8] = q.wstrb[1] ? q.wdata[15:8] : q.word[15:8];
		word_take = fetch_take || inject_take;
		word_in = fetch_take ? i_fetch_word : inj_word;
		dif.word = word_in;
	end

	// -----------------------------------------------------------------------
	// Read data mux
	// -----------------------------------------------------------------------
	logic [31:0] rd_mux; // Data for the addressed register
	logic rd_hit;        // Read address is mapped

	// Unused high bits read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (i_s_axi_araddr)
			REG_CTRL: rd_mux[CTRL_EN_BIT] = q.enable;
			REG_WORD: rd_mux[15:0] = q.word;
			REG_STATUS: begin
				rd_mux[ST_WAIT_BIT] = (q.seq == SEQ_TARGET);
				rd_mux[ST_TWO_BIT] = q.two_word;
				rd_mux[ST_UNK_BIT] = q.unknown;
				rd_mux[ST_MEM_BIT] = q.mem_op;
				rd_mux[ST_OP_LSB +: 6] = q.op;
				rd_mux[ST_COND_LSB +: 4] = q.cond;
			end
			REG_FIELDS: begin
				rd_mux[FLD_IMM_LSB +: 13] = q.mul_imm;
				rd_mux[FLD_SHIFT_LSB +: 2] = q.shift_sel;
				rd_mux[FLD_OFS_LSB +: 7] = q.page_offset;
				rd_mux[FLD_IND_BIT] = q.indirect;
			end
			REG_TARGET: rd_mux[15:0] = q.target;
			REG_COUNT: rd_mux = q.count;
			default: rd_hit = 1'b0;
		endcase
	end

	// -----------------------------------------------------------------------
	// Next-state logic
	// -----------------------------------------------------------------------
	always_comb begin
		d = q;
		d.dec_valid = 1'b0;

		// Decode sequencer
		if (word_take) begin
			unique case (q.seq)
				SEQ_TARGET: begin
					// Extension word is captured raw, never classified
					d.target = word_in;
					d.dec_valid = 1'b1;
					d.count = q.count + 32'h0000_0001;
					d.seq = SEQ_OPCODE;
				end
				SEQ_OPCODE: begin
					d.word = word_in;
					d.op = dif.op;
					d.cond = dif.cond;
					d.two_word = dif.two_word;
					d.mem_op = dif.mem_op;
					d.unknown = (dif.op == OP_UNKNOWN);
					d.indirect = dif.indirect;
					d.page_offset = dif.page_offset;
					d.mul_imm = dif.mul_imm;
					d.shift_sel = dif.shift_sel;
					if (dif.two_word) begin
						// Hold the strobe until the extension word arrives
						d.seq = SEQ_TARGET;
					end else begin
						d.dec_valid = 1'b1;
						d.count = q.count + 32'h0000_0001;
					end
				end
			endcase
		end

		// Write address and data are taken in either order
		if (q.awready && i_s_axi_awvalid) begin
			d.awready = 1'b0;
			d.awaddr = i_s_axi_awaddr;
		end
		if (q.wready && i_s_axi_wvalid) begin
			d.wready = 1'b0;
			d.wdata = i_s_axi_wdata;
			d.wstrb = i_s_axi_wstrb;
		end

		// Perform the write once both halves are in
		if (wr_ready && !wr_stall) begin
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			unique case (q.awaddr)
				REG_CTRL: begin
					if (q.wstrb[0]) begin
						d.enable = q.wdata[CTRL_EN_BIT];
					end
				end
				REG_WORD: ; // Taken by the sequencer above
				REG_STATUS, REG_FIELDS, REG_TARGET, REG_COUNT: ; // Read-only, ignored
				default: d.bresp = RESP_SLVERR;
			endcase
		end

		// Response accepted, free both slots
		if (q.bvalid && i_s_axi_bready) begin
			d.bvalid = 1'b0;
			d.awready = 1'b1;
			d.wready = 1'b1;
		end

		// Reads: one at a time, answered the cycle after the address
		if (q.arready && i_s_axi_arvalid) begin
			d.arready = 1'b0;
			d.rvalid = 1'b1;
			d.rdata = rd_mux;
			d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (q.rvalid && i_s_axi_rready) begin
			d.rvalid = 1'b0;
			d.arready = 1'b1;
		end
	end

	// -----------------------------------------------------------------------
	// State register
	// -----------------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q.seq <= SEQ_OPCODE;
			q.enable <= CTRL_EN_RST;
			q.word <= 16'h0000;
			q.dec_valid <= 1'b0;
			q.op <= OP_UNKNOWN;
			q.cond <= COND_NONE;
			q.two_word <= 1'b0;
			q.unknown <= 1'b0;
			q.mem_op <= 1'b0;
			q.indirect <= 1'b0;
			q.page_offset <= 7'h00;
			q.mul_imm <= 13'h0000;
			q.shift_sel <= 2'h0;
			q.target <= 16'h0000;
			q.count <= 32'h0000_0000;
			q.awready <= 1'b1;
			q.awaddr <= 8'h00;
			q.wready <= 1'b1;
			q.wdata <= 32'h0000_0000;
			q.wstrb <= 4'h0;
			q.bvalid <= 1'b0;
			q.bresp <= RESP_OKAY;
			q.arready <= 1'b1;
			q.rvalid <= 1'b0;
			q.rdata <= 32'h0000_0000;
			q.rresp <= RESP_OKAY;
		end else begin
			q <= d;
		end
	end

	// -----------------------------------------------------------------------
	// Outputs, all straight from flops
	// -----------------------------------------------------------------------
	assign o_dec_valid = q.dec_valid;
	assign o_op = q.op;
	assign o_cond = q.cond;
	assign o_two_word = q.two_word;
	assign o_unknown = q.unknown;
	assign o_mem_op = q.mem_op;
	assign o_indirect = q.indirect;
	assign o_page_offset = q.page_offset;
	assign o_mul_imm = q.mul_imm;
	assign o_shift_sel = q.shift_sel;
	assign o_target = q.target;
	assign o_wait_target = (q.seq == SEQ_TARGET);
	assign o_s_axi_awready = q.awready;
	assign o_s_axi_wready = q.wready;
	assign o_s_axi_bresp = q.bresp;
	assign o_s_axi_bvalid = q.bvalid;
	assign o_s_axi_arready = q.arready;
	assign o_s_axi_rdata = q.rdata;
	assign o_s_axi_rresp = q.rresp;
	assign o_s_axi_rvalid = q.rvalid;

endmodule : mbod_decoder

// >>> test/mbod_decoder_chk.sv
`timescale 1ns/100ps
// --------
// Port checks
// --------
module mbod_decoder_chk (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_fetch_valid,
	input wire logic [15:0] i_fetch_word,
	input wire logic o_dec_valid,
	input wire mbod_pkg::mbod_op_type o_op,
	input wire mbod_pkg::mbod_cond_type o_cond,
	input wire logic o_two_word,
	input wire logic o_unknown,
	input wire logic [12:0] o_mul_imm,
	input wire logic [1:0] o_shift_sel,
	input wire logic [15:0] o_target,
	input wire logic o_wait_target,
	input wire logic i_s_axi_arvalid,
	input wire logic o_s_axi_arready,
	input wire logic o_s_axi_rvalid
);
	import mbod_pkg::*;
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_reset_n);
	// One-word opcode taken by the previous edge
	sequence s_took;
		o_dec_valid && !o_two_word && $past(i_fetch_valid);
	endsequence
	a_sum_decode: assert property (s_took ##0 $past(i_fetch_word) == 16'hCE15
		|-> o_op == OP_ADD_PRODUCT_TO_ACC) else $error("product add word misdecoded");
	a_shift_pass: assert property (s_took ##0 $past(i_fetch_word[15:2]) == 14'h3382
		|-> o_op == OP_SET_SHIFT_SELECT && o_shift_sel == $past(i_fetch_word[1:0])) else $error("shift mode lost");
	a_imm_field: assert property (s_took ##0 $past(i_fetch_word[15:13]) == 3'h5
		|-> o_op == OP_MULTIPLY_IMMEDIATE && o_mul_imm == $past(i_fetch_word[12:0])) else $error("constant lost");
	a_wait_pair: assert property (o_wait_target |-> o_two_word && !o_dec_valid)
		else $error("early completion");
	// The word after a two-word opcode is its target, whatever it holds
	a_target_take: assert property (o_wait_target && i_fetch_valid
		|=> o_dec_valid && !o_wait_target && o_target == $past(i_fetch_word) && $stable(o_op))
		else $error("target word misused");
	a_jump_start: assert property (o_wait_target && !$past(o_wait_target)
		&& $past(i_fetch_word[15:7]) == 9'h1FF |-> o_op == OP_JUMP_ALWAYS && o_cond == COND_ALWAYS)
		else $error("plain jump misdecoded");
	a_unknown_flag: assert property (o_dec_valid |-> o_unknown == (o_op == OP_UNKNOWN))
		else $error("unknown flag wrong");
	a_test_cond: assert property (o_dec_valid && o_op == OP_JUMP_TEST_CLEAR
		|-> o_cond == COND_TEST_CLEAR && o_two_word) else $error("test flag condition wrong");
	a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
		else $error("read answer late");
	c_two_word: cover property (o_dec_valid && o_two_word);
	c_unknown: cover property (o_dec_valid && o_unknown);
	c_read: cover property (o_s_axi_rvalid);
endmodule : mbod_decoder_chk

bind mbod_decoder mbod_decoder_chk mbod_decoder_chk_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
	.i_fetch_valid(i_fetch_valid), .i_fetch_word(i_fetch_word), .o_dec_valid(o_dec_valid), .o_op(o_op),
	.o_cond(o_cond), .o_two_word(o_two_word), .o_unknown(o_unknown), .o_mul_imm(o_mul_imm),
	.o_shift_sel(o_shift_sel), .o_target(o_target), .o_wait_target(o_wait_target),
	.i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid));

// >>> test/mbod_decoder_test.sv
`timescale 1ns/100ps
module mbod_decoder_test;
	import mbod_pkg::*;
	// --------
	// Bench signals
	// --------
	logic clk, rst_n, fv, awv, wv, br, arv, rr; // Clock, reset, handshakes
	logic dv, tw, un, mo, ind, wt, awr, wrd, bv, arr, rv;
	logic [15:0] fw, tg, last_t;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd;
	logic [1:0] bre, rre, ss;
	logic [6:0] po;
	logic [12:0] im;
	mbod_op_type op;
	mbod_cond_type cd;
	int n_errors, total_checks, cyc;
	integer seed;
	logic [15:0] corner [35] = '{16'hCE15, 16'hCE14, 16'hCE16, 16'hCE0B, 16'h3C80, 16'h3D00, 16'h3F7F, 16'h3E81,
		16'h5B00, 16'h3800, 16'h3A00, 16'hBFFF, 16'h3B00, 16'hCF00, 16'h3900, 16'h5A00, 16'h5D00, 16'h5C00, 16'h5300,
		16'h7D00, 16'h7C00, 16'hFF80, 16'hCE25, 16'hFB80, 16'hF980, 16'hF880, 16'hF480, 16'hF180, 16'hF280,
		16'hF380, 16'hFA80, 16'hF780, 16'h5E80, 16'h5F80, 16'h0000};
	mbod_decoder mbod_decoder_inst (.i_core_clk(clk), .i_reset_n(rst_n), .i_fetch_valid(fv), .i_fetch_word(fw),
		.o_dec_valid(dv), .o_op(op), .o_cond(cd), .o_two_word(tw), .o_unknown(un), .o_mem_op(mo),
		.o_indirect(ind), .o_page_offset(po), .o_mul_imm(im), .o_shift_sel(ss), .o_target(tg),
		.o_wait_target(wt), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
		.i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd),
		.o_s_axi_bresp(bre), .o_s_axi_bvalid(bv), .i_s_axi_bready(br), .i_s_axi_araddr(ara),
		.i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rd), .o_s_axi_rresp(rre),
		.o_s_axi_rvalid(rv), .i_s_axi_rready(rr));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard: whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors = n_errors + 1;
			stop_test();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// Expected {two_word, cond, op} of an opcode word
	function automatic logic [10:0] want(input logic [15:0] w);
		mbod_op_type o;
		mbod_cond_type c;
		o = OP_UNKNOWN;
		casez (w[15:8])
			8'h3C: o = OP_LOAD_FACTOR_REG;
			8'h3D: o = OP_LOAD_T_ADD_PRODUCT;
			8'h3F: o = OP_LOAD_T_ADD_SHIFT_DATA;
			8'h3E: o = OP_LOAD_T_COPY_PRODUCT;
			8'h5B: o = OP_LOAD_T_SUB_PRODUCT;
			8'h38: o = OP_MULTIPLY_WORD;
			8'h3A: o = OP_MULTIPLY_ADD_PRIOR;
			8'hA?, 8'hB?: o = OP_MULTIPLY_IMMEDIATE;
			8'h3B: o = OP_MULTIPLY_SUB_PRIOR;
			8'hCF: o = OP_MULTIPLY_UNSIGNED;
			8'h39: o = OP_SQUARE_ADD;
			8'h5A: o = OP_SQUARE_SUB;
			8'h5D: o = OP_MUL_ACC_TWOWORD;
			8'h5C: o = OP_MUL_ACC_MOVE;
			8'h53: o = OP_LOAD_PRODUCT_HIGH;
			8'h7D: o = OP_STORE_PRODUCT_HIGH;
			8'h7C: o = OP_STORE_PRODUCT_LOW;
			default: ;
		endcase
		case (w)
			16'hCE15: o = OP_ADD_PRODUCT_TO_ACC;
			16'hCE14: o = OP_LOAD_ACC_FROM_PRODUCT;
			16'hCE16: o = OP_SUB_PRODUCT_FROM_ACC;
			16'hCE08, 16'hCE09, 16'hCE0A, 16'hCE0B: o = OP_SET_SHIFT_SELECT;
			16'hCE25: o = OP_JUMP_TO_ACC_TARGET;
			default: ;
		endcase
		case (w[15:7])
			9'h1FF: o = OP_JUMP_ALWAYS;
			9'h1F7: o = OP_JUMP_AUX_NONZERO;
			9'h1F3: o = OP_JUMP_TEST_SET;
			9'h1F1: o = OP_JUMP_TEST_CLEAR;
			9'h1E9: o = OP_JUMP_ACC_NONNEG;
			9'h1E3: o = OP_JUMP_ACC_POSITIVE;
			9'h1E5: o = OP_JUMP_ACC_NONPOS;
			9'h1E7: o = OP_JUMP_ACC_NEGATIVE;
			9'h1F5: o = OP_JUMP_IO_LOW;
			9'h1EF: o = OP_JUMP_NO_OVERFLOW;
			9'h0BD: o = OP_JUMP_ON_CARRY;
			9'h0BF: o = OP_JUMP_NO_CARRY;
			default: ;
		endcase
		// Conditional jumps list their conditions in the same order as their operations
		if (o == OP_JUMP_ALWAYS || o == OP_JUMP_TO_ACC_TARGET) c = COND_ALWAYS;
		else if (o >= OP_JUMP_AUX_NONZERO) c = mbod_cond_type'(4'(o - OP_JUMP_AUX_NONZERO) + 4'h2);
		else c = COND_NONE;
		return {o == OP_MUL_ACC_TWOWORD || o == OP_MUL_ACC_MOVE || (o >= OP_JUMP_ALWAYS && c != COND_ALWAYS)
			|| o == OP_JUMP_ALWAYS, c, o};
	endfunction : want
	// Offer one instruction; fetch stays high so calls run back to back
	task dec(input logic [15:0] w, input logic [15:0] t);
		logic [10:0] e;
		e = want(w);
		fv <= 1'b1;
		fw <= w;
		@(posedge clk);
		#1;
		if (e[10]) begin
			chk(wt, 1'b1);
			chk(dv, 1'b0);
			fw <= t;
			@(posedge clk);
			#1;
			chk(tg, t);
			last_t = t;
		end
		chk(dv, 1'b1);
		chk({tw, cd, op}, e);
		chk(un, e[5:0] == 6'h0);
		chk(mo, e[5:0] inside {[OP_LOAD_FACTOR_REG:OP_STORE_PRODUCT_LOW]} && e[5:0] != OP_MULTIPLY_IMMEDIATE);
		chk({ind, po, ss, im}, {w[7:0], w[1:0], w[12:0]});
	endtask : dec
	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrd) wv <= 1'b0;
		end while (!bv);
		br <= 1'b0;
		chk(bre, er);
	endtask : axw
	task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
		end while (!rv);
		rr <= 1'b0;
		chk(rd, ed);
		chk(rre, er);
	endtask : axr
	task stop_test;
		if (n_errors == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : stop_test
	// --------
	// Main sequence
	// --------
	initial begin
		seed = 32'h4EE30724;
		{n_errors, total_checks, cyc} = '0;
		{rst_n, fv, awv, wv, br, arv, rr} = '0;
		{fw, last_t, awa, ara, wd} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		axr(REG_CTRL, 32'(CTRL_EN_RST), RESP_OKAY);
		axr(8'h40, 32'h0, RESP_SLVERR);
		axw(8'h40, 32'h0, RESP_SLVERR);
		axw(REG_STATUS, 32'hFFFFFFFF, RESP_OKAY);
		foreach (corner[i]) dec(corner[i], 16'(i) ^ 16'hA5C3);
		repeat (400) dec(16'($random(seed)), 16'($random(seed)));
		fv <= 1'b0;
		// Fetch disabled: words are dropped without a decode
		axw(REG_CTRL, 32'h0, RESP_OKAY);
		fv <= 1'b1;
		fw <= 16'hCE15;
		repeat (3) begin
			@(posedge clk);
			#1;
			chk(dv, 1'b0);
		end
		fv <= 1'b0;
		axw(REG_CTRL, 32'h1, RESP_OKAY);
		axw(REG_WORD, 32'h0000CE14, RESP_OKAY);
		repeat (2) @(posedge clk);
		axr(REG_STATUS, 32'(OP_LOAD_ACC_FROM_PRODUCT) << ST_OP_LSB, RESP_OKAY);
		axr(REG_TARGET, {16'h0, last_t}, RESP_OKAY);
		axr(REG_FIELDS, (32'h0000_0014 << FLD_OFS_LSB) | (32'h0000_0E14 << FLD_IMM_LSB), RESP_OKAY);
		// Corner list, random words and the injected word, one count per instruction
		axr(REG_COUNT, 32'h0000_01B4, RESP_OKAY);
		stop_test();
	end
endmodule : mbod_decoder_test
